// ---- axd_defines.vh ----
// Purpose: Constants for the arithmetic exception detector
// Assumes: Hex floating point, 7-bit characteristic, excess 64
// Notes:   Interruption codes follow the program-check numbering
`ifndef AXD_DEFINES_VH
`define AXD_DEFINES_VH
`define AXD_CHAR_MAX      9'sh07F
`define AXD_CHAR_ADJ      9'sh080
`define AXD_ILC_DECIMAL   2'h3
`define AXD_OP_HALVE_LONG  8'h24
`define AXD_OP_HALVE_SHORT 8'h34
`define AXD_PSW_UFL_BIT   6'h26
`define AXD_PSW_SIG_BIT   6'h27
`define AXD_CODE_NONE     4'h0
`define AXD_CODE_DEC_DIV  4'hB
`define AXD_CODE_EXP_OVF  4'hC
`define AXD_CODE_EXP_UFL  4'hD
`define AXD_CODE_SIGNIF   4'hE
`define AXD_CODE_FP_DIV   4'hF
`define AXD_KIND_ADD      3'h0
`define AXD_KIND_SUB      3'h1
`define AXD_KIND_MUL      3'h2
`define AXD_KIND_DIV      3'h3
`define AXD_KIND_HALVE    3'h4
`define AXD_KIND_DECDIV   3'h5
`endif

// ---- axd_result_reg.v ----
// Purpose: Output register stage for one adjusted result word
// Assumes: Single clock, synchronous reset
// Notes:   Holds value until next load
`timescale 1ns/1ns
module axd_result_reg #(
    parameter W = 8
) (
    input  wire         mclk_i,
    input  wire         rst_i,
    input  wire         load_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] data_q;
    always @(posedge mclk_i) begin
        if (rst_i)
            data_q <= {W{1'b0}};
        else if (load_i)
            data_q <= d_i;
    end
    assign q_o = data_q;
endmodule

// ---- axd_arith_exception_detect.v ----
// Purpose: Detect arithmetic program exceptions and adjust results
// Assumes: Datapath gives true characteristic, normalized fraction
// Notes:   One request per cycle, answer one cycle later
// Notes:   Flags are one-hot; the highest priority exception wins
// Notes:   Result fields hold their value between requests
`timescale 1ns/1ns
`include "axd_defines.vh"
module axd_arith_exception_detect #(
    parameter FW = 56
) (
    // Clock and reset
    input  wire          mclk_i,
    input  wire          rst_i,
    // Operation result from the arithmetic datapath
    input  wire          req_i,
    input  wire [2:0]    op_kind_i,
    input  wire [7:0]    opcode_i,
    input  wire [1:0]    ilc_i,
    input  wire [63:0]   program_status_word_i,
    input  wire          dec_quot_too_big_i,
    input  wire          divisor_frac_zero_i,
    input  wire          res_sign_i,
    input  wire [8:0]    res_char_i,
    input  wire [FW-1:0] res_frac_i,
    // Answer towards the interruption logic
    output wire          done_o,
    output wire          suppress_o,
    output wire          exc_valid_o,
    output wire [3:0]    exc_code_o,
    output wire [1:0]    exc_ilc_o,
    output wire          decimal_divide_exc_o,
    output wire          significance_exc_o,
    output wire          float_divide_exc_o,
    output wire          exp_overflow_exc_o,
    output wire          exp_underflow_exc_o,
    // Adjusted result, stored for every request, suppressed ones included
    output wire          res_sign_o,
    output wire [6:0]    res_char_o,
    output wire [FW-1:0] res_frac_o
);
    ////////////////////////////////////////////////////////////////
    // Bit positions inside the registered flag vector
    localparam FLG_DEC = 0;
    localparam FLG_SIG = 1;
    localparam FLG_FPD = 2;
    localparam FLG_OVF = 3;
    localparam FLG_UFL = 4;

    ////////////////////////////////////////////////////////////////
    // Operation decode; opcode alone also marks a halve, so a
    // datapath that mislabels the kind cannot raise overflow
    wire       is_fp_as = (op_kind_i == `AXD_KIND_ADD) ||
                          (op_kind_i == `AXD_KIND_SUB);
    wire       is_div   = (op_kind_i == `AXD_KIND_DIV);
    wire       is_dec   = (op_kind_i == `AXD_KIND_DECDIV);
    wire       is_halve = (op_kind_i == `AXD_KIND_HALVE) ||
                          (opcode_i == `AXD_OP_HALVE_LONG) ||
                          (opcode_i == `AXD_OP_HALVE_SHORT);
    wire       is_fp    = !is_dec;
    wire       frac_nz  = |res_frac_i;
    wire signed [8:0] chr = res_char_i;
    wire       ufl_mask = program_status_word_i[`AXD_PSW_UFL_BIT];
    wire       sig_mask = program_status_word_i[`AXD_PSW_SIG_BIT];

    wire dec_exc = is_dec && dec_quot_too_big_i;
    wire fpd_exc = is_div && divisor_frac_zero_i;
    // Halve is excluded from overflow by construction
    wire ovf_exc = is_fp && !is_halve && !fpd_exc &&
                   (chr > `AXD_CHAR_MAX) && frac_nz;
    wire ufl_exc = is_fp && !fpd_exc &&
                   (chr < 9'sh000) && frac_nz;
    wire sig_exc = is_fp_as && !frac_nz;

    ////////////////////////////////////////////////////////////////
    // One-hot flags in priority order; a suppressed divide must
    // not also report a result exception it never produced
    wire flag_dec = dec_exc;
    wire flag_fpd = fpd_exc && !dec_exc;
    wire flag_ovf = ovf_exc && !dec_exc && !fpd_exc;
    wire flag_ufl = ufl_exc && !dec_exc && !fpd_exc &&
                    !ovf_exc;
    wire flag_sig = sig_exc && !dec_exc && !fpd_exc &&
                    !ovf_exc && !ufl_exc;
    wire suppress = dec_exc || fpd_exc;

    ////////////////////////////////////////////////////////////////
    // Result adjustment; by default the datapath value passes
    // through unchanged, and each branch below only overrides
    // what its exception alters
    ////////////////////////////////////////////////////////////////
    reg          sign_d;
    reg  [8:0]   char_d;
    reg  [FW-1:0] frac_d;
    reg  [3:0]   code_d;
    reg  [1:0]   ilc_d;
    always @* begin
        sign_d = res_sign_i;
        char_d = res_char_i;
        frac_d = res_frac_i;
        code_d = `AXD_CODE_NONE;
        ilc_d  = ilc_i;
        if (dec_exc) begin
            code_d = `AXD_CODE_DEC_DIV;
            ilc_d  = `AXD_ILC_DECIMAL;
        end else if (fpd_exc) begin
            // Suppressed: result is still loaded, and the consumer must discard it
            code_d = `AXD_CODE_FP_DIV;
        end else if (ovf_exc) begin
            // Low seven bits keep the wrapped characteristic
            code_d = `AXD_CODE_EXP_OVF;
            char_d = res_char_i - `AXD_CHAR_ADJ;
        end else if (ufl_exc) begin
            code_d = `AXD_CODE_EXP_UFL;
            if (ufl_mask) begin
                char_d = res_char_i + `AXD_CHAR_ADJ;
            end else begin
                sign_d = 1'b0;
                char_d = 9'h000;
                frac_d = {FW{1'b0}};
            end
        end else if (sig_exc) begin
            code_d = `AXD_CODE_SIGNIF;
            // Unmasked keeps characteristic; masked-off gives true zero
            if (!sig_mask) begin
                sign_d = 1'b0;
                char_d = 9'h000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Handshake and suppression status
    reg       done_q;
    reg       supp_q;
    always @(posedge mclk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            supp_q <= 1'b0;
        end else begin
            done_q <= req_i;
            supp_q <= req_i && suppress;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Code reads as zero between requests, so a stale code can
    // never be taken for a new exception
    reg [3:0] code_q;
    always @(posedge mclk_i) begin
        if (rst_i)
            code_q <= `AXD_CODE_NONE;
        else
            code_q <= req_i ? code_d : `AXD_CODE_NONE;
    end

    // Length code follows the same idle rule as the code
    reg [1:0] ilc_q;
    always @(posedge mclk_i) begin
        if (rst_i)
            ilc_q <= 2'h0;
        else
            ilc_q <= req_i ? ilc_d : 2'h0;
    end

    ////////////////////////////////////////////////////////////////
    // Single-cycle flag pulses for the interruption logic
    reg [4:0] flags_q;
    always @(posedge mclk_i) begin
        if (rst_i) begin
            flags_q <= 5'h00;
        end else if (req_i) begin
            flags_q[FLG_DEC] <= flag_dec;
            flags_q[FLG_SIG] <= flag_sig;
            flags_q[FLG_FPD] <= flag_fpd;
            flags_q[FLG_OVF] <= flag_ovf;
            flags_q[FLG_UFL] <= flag_ufl;
        end else begin
            flags_q <= 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Result word register; loads on every request, including
    // suppressed ones, whose value the consumer must discard

    axd_result_reg #(
        .W (FW + 8)
    ) u_res (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .load_i (req_i),
        .d_i    ({sign_d, char_d[6:0], frac_d}),
        .q_o    ({res_sign_o, res_char_o, res_frac_o})
    );

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign done_o               = done_q;
    assign suppress_o           = supp_q;
    assign exc_valid_o          = done_q && (code_q != `AXD_CODE_NONE);
    assign exc_code_o           = code_q;
    assign exc_ilc_o            = ilc_q;
    assign decimal_divide_exc_o = flags_q[FLG_DEC];
    assign significance_exc_o   = flags_q[FLG_SIG];
    assign float_divide_exc_o   = flags_q[FLG_FPD];
    assign exp_overflow_exc_o   = flags_q[FLG_OVF];
    assign exp_underflow_exc_o  = flags_q[FLG_UFL];
endmodule

// ---- axd_checker_assertions.sv ----
// Purpose: Port checks of the arithmetic exception detector
// Assumes: Answer one cycle after each request
// Notes:   Bound to every detector instance
`timescale 1ns/1ns
module axd_checker (
    input wire       mclk_i,
    input wire       rst_i,
    input wire       req_i,
    input wire [2:0] op_kind_i,
    input wire [7:0] opcode_i,
    input wire       dec_quot_too_big_i,
    input wire       divisor_frac_zero_i,
    input wire       done_o,
    input wire       suppress_o,
    input wire       exc_valid_o,
    input wire [3:0] exc_code_o,
    input wire [1:0] exc_ilc_o,
    input wire       decimal_divide_exc_o,
    input wire       float_divide_exc_o,
    input wire       exp_overflow_exc_o
);
    default clocking dc @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    wire hv = op_kind_i == 3'h4 || opcode_i == 8'h24 || opcode_i == 8'h34;
    wire dk = req_i && op_kind_i == 3'h5 && dec_quot_too_big_i;
    wire fk = req_i && op_kind_i == 3'h3 && divisor_frac_zero_i;
    done_rise_a: assert property (req_i |=> done_o)
        else $error("done missing");
    done_idle_a: assert property (!req_i |=> !done_o)
        else $error("stray done");
    dec_div_a: assert property (dk |=> suppress_o && exc_ilc_o == 2'h3)
        else $error("decimal divide wrong");
    fp_div_a: assert property (fk && !dk |=> float_divide_exc_o)
        else $error("fp divide missing");
    halve_ovf_a: assert property (req_i && hv |=> !exp_overflow_exc_o)
        else $error("halve overflow");
    exc_valid_a: assert property (exc_valid_o == (done_o && |exc_code_o))
        else $error("valid wrong");
    supp_src_a: assert property (suppress_o == (decimal_divide_exc_o || float_divide_exc_o))
        else $error("suppress wrong");
    ovf_code_a: assert property (exp_overflow_exc_o == (exc_valid_o && exc_code_o == 4'hC))
        else $error("overflow flag wrong");
    cover property (dk);
    cover property (req_i && hv);
    cover property (exp_overflow_exc_o);
endmodule
bind axd_arith_exception_detect axd_checker i_chk (.*);

// ---- axd_irq_model.sv ----
// Purpose: Interruption side, counts reported exceptions
// Assumes: Valid pulses last one cycle
// Notes:   Count is compared by the bench at the end
`timescale 1ns/1ns
module axd_irq_model (
    input  wire       mclk_i,
    input  wire       rst_i,
    input  wire       valid_i,
    input  wire [3:0] code_i,
    output integer    taken_o
);
    always @(posedge mclk_i) begin
        if (rst_i)
            taken_o <= 0;
        else if (valid_i && code_i != 4'h0)
            taken_o <= taken_o + 1;
    end
endmodule

// ---- axd_tb.sv ----
// Purpose: Random self-check of the exception detector
// Assumes: One request per cycle, answer one cycle later
// Notes:   Result fields compared only where defined
`timescale 1ns/1ns
`include "axd_defines.vh"
module testbench;
    localparam FW = 56;
    reg           mclk_i, rst_i, req_i, dec_quot_too_big_i;
    reg           divisor_frac_zero_i, res_sign_i, ereq, es, cmp;
    reg  [2:0]    op_kind_i;
    reg  [7:0]    opcode_i;
    reg  [1:0]    ilc_i, ei;
    reg  [63:0]   program_status_word_i, w;
    reg  [8:0]    res_char_i;
    reg  [FW-1:0] res_frac_i, ef;
    reg  [3:0]    e;
    reg  [6:0]    ec;
    wire          done_o, suppress_o, exc_valid_o, res_sign_o;
    wire          decimal_divide_exc_o, significance_exc_o;
    wire          float_divide_exc_o, exp_overflow_exc_o;
    wire          exp_underflow_exc_o;
    wire [3:0]    exc_code_o;
    wire [1:0]    exc_ilc_o;
    wire [6:0]    res_char_o;
    wire [FW-1:0] res_frac_o;
    integer       seed, n_fail, checked, cyc, i, r, taken, n_exc;
    axd_arith_exception_detect #(.FW(FW)) i_dut (.*);
    axd_irq_model i_irq (.mclk_i(mclk_i), .rst_i(rst_i),
        .valid_i(exc_valid_o), .code_i(exc_code_o), .taken_o(taken));
    initial begin
        mclk_i = 0;
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            n_fail = n_fail + 1;
            report_and_stop;
        end
    end
    task cmp_val(input logic [63:0] got, input logic [63:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED t=%0t %h %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d failures %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task gen;
        begin
            r = $random(seed);
            w = {$random(seed), $random(seed)};
            {req_i, ilc_i, dec_quot_too_big_i} = {|r[2:0], r[10:9], r[11]};
            {divisor_frac_zero_i, res_sign_i} = r[13:12];
            op_kind_i = 3'(r[7:3] % 5'h6);
            opcode_i = op_kind_i != 3'h4 ? 8'h2A : r[8] ? 8'h24 : 8'h34;
            program_status_word_i = {$random(seed), $random(seed)};
            res_char_i = w[63:55];
            // Boundary characteristics need far more hits than random
            case (r[17:14])
                4'h0: res_char_i = 9'h07F;
                4'h1: res_char_i = 9'h080;
                4'h2: res_char_i = 9'h000;
                4'h3: res_char_i = 9'h1FF;
            endcase
            res_frac_i = r[19:18] == 2'h0 ? '0 : w[FW-1:0] | 1'b1 << FW-1;
            {ereq, e, cmp, es, ei, ef} = {req_i, 4'h0, 1'b0, res_sign_i,
                ilc_i, res_frac_i};
            ec = res_char_i[6:0];
            if (op_kind_i == 3'h5 && dec_quot_too_big_i)
                {e, ei} = {`AXD_CODE_DEC_DIV, `AXD_ILC_DECIMAL};
            else if (op_kind_i == 3'h3 && divisor_frac_zero_i)
                e = `AXD_CODE_FP_DIV;
            else if (op_kind_i < 3'h5 && res_frac_i != '0) begin
                cmp = op_kind_i != 3'h4 || $signed(res_char_i) < 128;
                if ($signed(res_char_i) > 127 && op_kind_i != 3'h4)
                    e = `AXD_CODE_EXP_OVF;
                else if ($signed(res_char_i) < 0)
                    e = `AXD_CODE_EXP_UFL;
            end else if (op_kind_i < 3'h2) begin
                {e, cmp} = {`AXD_CODE_SIGNIF, 1'b1};
                if (!program_status_word_i[39])
                    {es, ec} = '0;
            end
            if (e == `AXD_CODE_EXP_UFL && !program_status_word_i[38])
                {es, ec, ef} = '0;
        end
    endtask
    task check;
        begin
            cmp_val(done_o, ereq);
            cmp_val(exc_valid_o, ereq && e != 4'h0);
            cmp_val({exp_underflow_exc_o, exp_overflow_exc_o,
                float_divide_exc_o, significance_exc_o,
                decimal_divide_exc_o}, {5{ereq}} & {e == 4'hD,
                e == 4'hC, e == 4'hF, e == 4'hE, e == 4'hB});
            if (ereq) begin
                cmp_val(exc_code_o, e);
                cmp_val(suppress_o, e == 4'hB || e == 4'hF);
                if (e != 4'h0)
                    cmp_val(exc_ilc_o, ei);
                if (cmp)
                    cmp_val({res_sign_o, res_char_o, res_frac_o},
                        {es, ec, ef});
            end
        end
    endtask
    initial begin
        {seed, n_fail, checked, cyc, n_exc} = {32'd24789, 128'd0};
        rst_i = 1;
        gen;
        {req_i, ereq} = 2'h0;
        repeat (20) @(posedge mclk_i);
        #1 rst_i = 0;
        for (i = 0; i < 4001; i = i + 1) begin
            @(posedge mclk_i);
            #1;
            if (i > 0)
                check;
            gen;
            n_exc = n_exc + (req_i && e != 4'h0 && i < 4000);
            req_i = req_i && i < 4000;
        end
        @(posedge mclk_i);
        #1 cmp_val(taken, n_exc);
        $display("random test done");
        report_and_stop;
    end
endmodule
